// ---- accel_map.vh ----
// Constants for the accelerometer two-wire slave and its register window.
// Assumes a 50 MHz system clock; included by every design file except the line synchroniser.
`ifndef ACCEL_MAP_VH
`define ACCEL_MAP_VH

// ----------------------------------------------------------------
// Slave address
// ----------------------------------------------------------------
`define DEV_ADDR_UPPER 4'h2

// ----------------------------------------------------------------
// Register window positions
// ----------------------------------------------------------------
`define POS_CTRL 3'h0
`define POS_X_HI 3'h1
`define POS_X_LO 3'h2
`define POS_Y_HI 3'h3
`define POS_Y_LO 3'h4
`define POS_LAST 3'h6
`define PTR_LIMIT 8'h07

// ----------------------------------------------------------------
// Control register fields and reset value
// ----------------------------------------------------------------
`define CTRL_SLEEP_BIT 0
`define CTRL_SELF_CHECK_BIT 1
`define CTRL_REF_CHECK_BIT 2
`define CTRL_THERMAL_SEL_BIT 3
`define CTRL_RESET 8'h00

// ----------------------------------------------------------------
// Result format
// ----------------------------------------------------------------
`define RESULT_ZERO_G 12'h800

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SYS_CLK_MHZ 50
`define REFRESH_PERIOD_US 10000
`define WAKE_TIME_US 75000
`define REFRESH_CYCLES (`REFRESH_PERIOD_US * `SYS_CLK_MHZ)
`define WAKE_CYCLES (`WAKE_TIME_US * `SYS_CLK_MHZ)

`endif

// ---- i2c_line_sync.v ----
// Two-wire line synchroniser with edge, start and stop detection.
// Assumes SCL and SDA arrive asynchronously and are far slower than sys_clk_i.
module i2c_line_sync (
  input wire sys_clk_i,
  input wire reset_n_i,
  input wire clk_en_i,
  input wire scl_i,
  input wire sda_i,
  output wire scl_rise_o,
  output wire scl_fall_o,
  output wire start_o,
  output wire stop_o,
  output wire sda_level_o
);

  reg scl_s1_r;
  reg scl_s2_r;
  reg scl_d_r;
  reg sda_s1_r;
  reg sda_s2_r;
  reg sda_d_r;

  // ----------------------------------------------------------------
  // Two-stage synchronisers, then one history stage
  // ----------------------------------------------------------------
  // Idle level is high so a reset never fakes a start or stop
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else if (clk_en_i) begin
      scl_s1_r <= scl_i;
      scl_s2_r <= scl_s1_r;
      scl_d_r <= scl_s2_r;
      sda_s1_r <= sda_i;
      sda_s2_r <= sda_s1_r;
      sda_d_r <= sda_s2_r;
    end
  end

  // ----------------------------------------------------------------
  // Event pulses
  // ----------------------------------------------------------------
  // SDA moving while SCL stays high marks start or stop [R1] [R21]
  assign scl_rise_o = clk_en_i & scl_s2_r & ~scl_d_r;
  assign scl_fall_o = clk_en_i & ~scl_s2_r & scl_d_r;
  assign start_o = clk_en_i & scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r; // [R1]
  assign stop_o = clk_en_i & scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r; // [R1]
  assign sda_level_o = sda_s2_r;

endmodule // i2c_line_sync

// ---- sample_refresh.v ----
// Result refresh timer and power-up settling for the sensing path.
// Assumes converter results are stable words in the sys_clk_i domain.
`include "accel_map.vh"
module sample_refresh #(
  parameter REFRESH_CYCLES = `REFRESH_CYCLES,
  parameter WAKE_CYCLES = `WAKE_CYCLES
) (
  input wire sys_clk_i,
  input wire reset_n_i,
  input wire clk_en_i,
  input wire sleep_request_i,
  input wire [11:0] x_accel_i,
  input wire [11:0] y_accel_i,
  input wire [11:0] thermal_result_i,
  output reg [15:0] x_word_o,
  output reg [15:0] y_word_o,
  output reg [15:0] t_word_o,
  output reg measure_valid_o
);

  localparam integer REF_LAST_I = REFRESH_CYCLES - 1;
  localparam integer WAKE_LAST_I = WAKE_CYCLES - 1;
  // Both counts fit in 23 bits, so the cut to counter width is safe
  localparam [22:0] REF_LAST = REF_LAST_I[22:0];
  localparam [22:0] WAKE_LAST = WAKE_LAST_I[22:0];

  reg [22:0] ref_cnt_r;
  reg [22:0] wake_cnt_r;

  // ----------------------------------------------------------------
  // Settling after wake, then periodic capture
  // ----------------------------------------------------------------
  // Results freeze while asleep; the last capture stays readable
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ref_cnt_r <= 23'h000000;
      wake_cnt_r <= 23'h000000;
      measure_valid_o <= 1'b0;
      x_word_o <= {4'h0, `RESULT_ZERO_G};
      y_word_o <= {4'h0, `RESULT_ZERO_G};
      t_word_o <= 16'h0000;
    end else if (clk_en_i) begin
      if (sleep_request_i) begin
        wake_cnt_r <= 23'h000000; // Full settling on every wake [R18]
        ref_cnt_r <= 23'h000000;
        measure_valid_o <= 1'b0;
      end else if (!measure_valid_o) begin
        if (wake_cnt_r == WAKE_LAST) begin
          measure_valid_o <= 1'b1; // [R18]
        end else begin
          wake_cnt_r <= wake_cnt_r + 23'h000001;
        end
      end else if (ref_cnt_r == REF_LAST) begin
        ref_cnt_r <= 23'h000000;
        // Upper nibble forced to zero on every axis [R15]
        x_word_o <= {4'h0, x_accel_i}; // [R16]
        y_word_o <= {4'h0, y_accel_i}; // [R16]
        t_word_o <= {4'h0, thermal_result_i};
      end else begin
        ref_cnt_r <= ref_cnt_r + 23'h000001;
      end
    end
  end

endmodule // sample_refresh

// ---- accel_i2c_slave_regs.v ----
// Two-wire slave and register window of a dual-axis accelerometer.
// Assumes an external master on SCL/SDA with pull-ups; SDA is open drain.
//
// Summary of operation
// R1: Detect START (SDA falls, SCL high) and STOP (SDA rises, SCL high).
// R2: Bytes are eight bits, MSB first, then one acknowledge bit.
// R3: Answer only to address 0010 followed by the three strap bits.
// R4: Eighth address bit: one means read, zero means write.
// R5: Acknowledge a matching address and every written byte on ninth clock.
// R6: Master writes register address zero before the control byte.
// R7: Control bit 0 set requests power-down; clear keeps sensor powered.
// R8: Control bit 1 enables self-test.
// R9: Control bit 2 selects bandgap test mode for the temperature path.
// R10: Control bit 3 returns temperature in the two X positions.
// R11: In a read, send a byte per nine clocks while master acknowledges.
// R12: Positions: control, X high, X low, Y high, Y low; any start.
// R13: Pointer increments by one after each read byte.
// R14: Positions five and six read zero; then pointer wraps to zero.
// R15: Axis results are 16-bit, 12 significant bits, upper bits zero.
// R16: Results refresh at about 100 Hz; master waits about 20 ms.
// R17: A withheld acknowledge ends the read; SDA is released.
// R18: Clearing power-down wakes sensor; results valid after about 75 ms.
// R19: Reading position zero returns the current control register.
// R20: Master writes start pointer, then re-addresses with read bit set.
// R21: SDA changes only while SCL is low; bus free when both high.
// R22: Release SDA after eighth sent bit; sample master ack on ninth.
// R23: Bits 4 to 7 are plain storage; every write loads the pointer.
`include "accel_map.vh"
module accel_i2c_slave_regs #(
  parameter REFRESH_CYCLES = `REFRESH_CYCLES,
  parameter WAKE_CYCLES = `WAKE_CYCLES
) (
  input wire sys_clk_i,
  input wire reset_n_i,
  input wire clk_en_i,
  input wire scl_i,
  input wire sda_i,
  output wire sda_o,
  output reg sda_oe_o,
  input wire [2:0] addr_strap_i,
  input wire [11:0] x_accel_i,
  input wire [11:0] y_accel_i,
  input wire [11:0] thermal_result_i,
  output wire sleep_request_o,
  output wire self_check_enable_o,
  output wire reference_check_mode_o,
  output wire thermal_output_select_o,
  output wire measure_valid_o
);

  // ----------------------------------------------------------------
  // State encoding
  // ----------------------------------------------------------------
  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_ADDR = 4'h1;
  localparam [3:0] ST_ADDR_ACK = 4'h2;
  localparam [3:0] ST_WR_PTR = 4'h3;
  localparam [3:0] ST_PTR_ACK = 4'h4;
  localparam [3:0] ST_WR_DATA = 4'h5;
  localparam [3:0] ST_DATA_ACK = 4'h6;
  localparam [3:0] ST_RD_DATA = 4'h7;
  localparam [3:0] ST_RD_ACK = 4'h8;

  reg [3:0] state_r;
  reg [3:0] bit_cnt_r;
  reg [7:0] rx_r;
  reg [7:0] tx_r;
  reg [2:0] ptr_r;
  reg rd_dir_r;
  reg master_ack_r;
  reg [7:0] ctrl_r;
  reg [2:0] strap_r;
  reg strap_taken_r;

  wire scl_rise;
  wire scl_fall;
  wire start_evt;
  wire stop_evt;
  wire sda_level;
  wire [15:0] x_word;
  wire [15:0] y_word;
  wire [15:0] t_word;
  wire [7:0] rx_full;
  wire addr_match;
  wire [7:0] window_byte;

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  i2c_line_sync u_sync (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .clk_en_i(clk_en_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .scl_rise_o(scl_rise),
    .scl_fall_o(scl_fall),
    .start_o(start_evt),
    .stop_o(stop_evt),
    .sda_level_o(sda_level)
  );

  sample_refresh #(
    .REFRESH_CYCLES(REFRESH_CYCLES),
    .WAKE_CYCLES(WAKE_CYCLES)
  ) u_refresh (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .clk_en_i(clk_en_i),
    .sleep_request_i(ctrl_r[`CTRL_SLEEP_BIT]),
    .x_accel_i(x_accel_i),
    .y_accel_i(y_accel_i),
    .thermal_result_i(thermal_result_i),
    .x_word_o(x_word),
    .y_word_o(y_word),
    .t_word_o(t_word),
    .measure_valid_o(measure_valid_o)
  );

  // ----------------------------------------------------------------
  // Read window decode
  // ----------------------------------------------------------------
  // Used both after the address ack and after each master ack
  function [7:0] read_byte;
    input [2:0] pos;
    input [7:0] ctrl;
    input [15:0] xw;
    input [15:0] yw;
    input [15:0] tw;
    reg [15:0] first;
    begin
      // X positions carry temperature when selected [R10]
      first = ctrl[`CTRL_THERMAL_SEL_BIT] ? tw : xw;
      case (pos)
        `POS_CTRL: read_byte = ctrl; // [R19] [R12]
        `POS_X_HI: read_byte = first[15:8]; // [R12]
        `POS_X_LO: read_byte = first[7:0]; // [R12]
        `POS_Y_HI: read_byte = yw[15:8]; // [R12]
        `POS_Y_LO: read_byte = yw[7:0]; // [R12]
        default: read_byte = 8'h00; // Spare positions read zero [R14]
      endcase
    end
  endfunction

  // Pointer step with wrap after the last spare position
  function [2:0] next_ptr;
    input [2:0] pos;
    begin
      if (pos == `POS_LAST) begin
        next_ptr = `POS_CTRL; // [R14]
      end else begin
        next_ptr = pos + 3'h1; // [R13]
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  // Strap is sampled once after reset release, never by the reset itself
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      strap_r <= 3'h0;
      strap_taken_r <= 1'b0;
    end else if (clk_en_i && !strap_taken_r) begin
      strap_r <= addr_strap_i;
      strap_taken_r <= 1'b1;
    end
  end

  // Byte as it stands once the eighth bit has been shifted in
  assign rx_full = rx_r;
  assign addr_match = (rx_full[7:1] == {`DEV_ADDR_UPPER, strap_r}); // [R3]
  // Byte at the pointer; its MSB goes out first, so only bit 7 is taken here
  assign window_byte = read_byte(ptr_r, ctrl_r, x_word, y_word, t_word);

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  assign sleep_request_o = ctrl_r[`CTRL_SLEEP_BIT]; // [R7] [R18]
  assign self_check_enable_o = ctrl_r[`CTRL_SELF_CHECK_BIT]; // [R8]
  assign reference_check_mode_o = ctrl_r[`CTRL_REF_CHECK_BIT]; // [R9]
  assign thermal_output_select_o = ctrl_r[`CTRL_THERMAL_SEL_BIT]; // [R10]
  // Open drain: only ever pulls low, the enable carries the data
  assign sda_o = 1'b0;

  // ----------------------------------------------------------------
  // Bus protocol engine
  // ----------------------------------------------------------------
  // All SDA changes happen on the SCL falling edge, so the line is
  // steady for the whole high phase and never mimics start or stop.
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      rx_r <= 8'h00;
      tx_r <= 8'h00;
      ptr_r <= `POS_CTRL;
      rd_dir_r <= 1'b0;
      master_ack_r <= 1'b0;
      ctrl_r <= `CTRL_RESET;
      sda_oe_o <= 1'b0;
    end else if (clk_en_i) begin
      if (start_evt) begin
        // Repeated start allowed anywhere; pointer kept for reads [R1] [R20]
        state_r <= ST_ADDR;
        bit_cnt_r <= 4'h0;
        sda_oe_o <= 1'b0;
      end else if (stop_evt) begin
        state_r <= ST_IDLE; // [R1] [R17]
        sda_oe_o <= 1'b0;
      end else begin
        case (state_r)
          ST_IDLE: begin
            sda_oe_o <= 1'b0;
          end
          ST_ADDR, ST_WR_PTR, ST_WR_DATA: begin
            if (scl_rise && bit_cnt_r != 4'h8) begin
              rx_r <= {rx_r[6:0], sda_level}; // MSB first [R2] [R21]
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_fall && bit_cnt_r == 4'h8) begin
              bit_cnt_r <= 4'h0;
              if (state_r == ST_ADDR && !addr_match) begin
                state_r <= ST_IDLE; // Not ours: stay off the line [R3]
              end else begin
                sda_oe_o <= 1'b1; // Pull low for the ninth clock [R5]
                case (state_r)
                  ST_ADDR: begin
                    rd_dir_r <= rx_full[0]; // [R4]
                    state_r <= ST_ADDR_ACK;
                  end
                  ST_WR_PTR: begin
                    // Out-of-window pointer values fall back to zero [R23]
                    if (rx_full < `PTR_LIMIT) begin
                      ptr_r <= rx_full[2:0];
                    end else begin
                      ptr_r <= `POS_CTRL;
                    end
                    state_r <= ST_PTR_ACK;
                  end
                  default: begin
                    // Only position zero is writable; others ack and drop [R6]
                    if (ptr_r == `POS_CTRL) begin
                      ctrl_r <= rx_full; // [R7] [R8] [R9] [R10] [R23]
                    end
                    ptr_r <= next_ptr(ptr_r);
                    state_r <= ST_DATA_ACK;
                  end
                endcase
              end
            end
          end
          ST_ADDR_ACK: begin
            if (scl_fall) begin
              if (rd_dir_r) begin
                tx_r <= read_byte(ptr_r, ctrl_r, x_word, y_word, t_word);
                sda_oe_o <= ~window_byte[7];
                state_r <= ST_RD_DATA; // [R11] [R4]
              end else begin
                sda_oe_o <= 1'b0;
                state_r <= ST_WR_PTR;
              end
            end
          end
          ST_PTR_ACK, ST_DATA_ACK: begin
            if (scl_fall) begin
              sda_oe_o <= 1'b0; // Release after the ack clock [R5]
              state_r <= ST_WR_DATA;
            end
          end
          ST_RD_DATA: begin
            if (scl_rise) begin
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt_r == 4'h8) begin
                sda_oe_o <= 1'b0; // Hand SDA to the master for its ack [R22]
                ptr_r <= next_ptr(ptr_r); // [R13] [R14]
                state_r <= ST_RD_ACK;
              end else begin
                tx_r <= {tx_r[6:0], 1'b0};
                sda_oe_o <= ~tx_r[6]; // Next bit, MSB first [R2]
              end
            end
          end
          ST_RD_ACK: begin
            if (scl_rise) begin
              master_ack_r <= ~sda_level; // [R22]
            end else if (scl_fall) begin
              bit_cnt_r <= 4'h0;
              if (master_ack_r) begin
                tx_r <= read_byte(ptr_r, ctrl_r, x_word, y_word, t_word);
                sda_oe_o <= ~window_byte[7];
                state_r <= ST_RD_DATA; // Keep sending while acked [R11]
              end else begin
                sda_oe_o <= 1'b0; // No ack: stop sending [R17]
                state_r <= ST_IDLE;
              end
            end
          end
          default: begin
            state_r <= ST_IDLE;
            sda_oe_o <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule // accel_i2c_slave_regs

// ---- accel_i2c_slave_regs_assertions.sv ----
// Checker for the accelerometer two-wire slave, bound to its top module.
// Assumes the bench uses shortened wake and refresh counts.
module accel_i2c_slave_regs_checker #(
  parameter REFRESH_CYCLES = 20,
  parameter WAKE_CYCLES = 10
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic scl_i,
  input wire logic sda_oe_o,
  input wire logic sleep_request_o,
  input wire logic self_check_enable_o,
  input wire logic reference_check_mode_o,
  input wire logic thermal_output_select_o,
  input wire logic measure_valid_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] ctrl_pins;
  logic [3:0] since_rst_r;
  int awake_cnt_r;
  assign ctrl_pins = {thermal_output_select_o, reference_check_mode_o,
                      self_check_enable_o, sleep_request_o};
  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  // Awake count saturates so it never wraps on long runs
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      since_rst_r <= 4'h0;
      awake_cnt_r <= 0;
    end else begin
      if (since_rst_r != 4'hf) since_rst_r <= since_rst_r + 4'h1;
      if (sleep_request_o) awake_cnt_r <= 0;
      else if (clk_en_i && awake_cnt_r < WAKE_CYCLES + 8) awake_cnt_r <= awake_cnt_r + 1;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  // Acknowledge held for one whole bus clock, then released
  sequence s_ack_hold;
    sda_oe_o [*6] ##[1:6] !sda_oe_o;
  endsequence
  a_oe_stable_high: assert property ((scl_i && $past(scl_i)) |-> $stable(sda_oe_o))
    else $error("data drive changed while bus clock high");
  a_oe_after_fall: assert property (($rose(sda_oe_o) || $fell(sda_oe_o))
    |-> !scl_i && $past(scl_i, 6) && !$past(scl_i, 2))
    else $error("data drive changed away from a bus clock fall");
  a_ctrl_scl_low: assert property ($changed(ctrl_pins) |-> !scl_i)
    else $error("control outputs changed while bus clock high");
  a_ctrl_ack_slot: assert property ($changed(ctrl_pins) |-> s_ack_hold)
    else $error("control update without a full acknowledge");
  a_quiet_reset: assert property (since_rst_r < 4'h4 |-> !sda_oe_o && ctrl_pins == 4'h0)
    else $error("outputs active just after reset");
  a_valid_awake: assert property ($rose(measure_valid_o) |-> !sleep_request_o)
    else $error("results valid while asleep");
  a_wake_delay: assert property ($rose(measure_valid_o) |-> awake_cnt_r >= WAKE_CYCLES - 2)
    else $error("results valid before the wake time");
  a_wake_bound: assert property ((!sleep_request_o && awake_cnt_r == WAKE_CYCLES + 4)
    |-> measure_valid_o)
    else $error("results still not valid after the wake time");
endmodule // accel_i2c_slave_regs_checker

bind accel_i2c_slave_regs accel_i2c_slave_regs_checker #(
  .REFRESH_CYCLES(REFRESH_CYCLES), .WAKE_CYCLES(WAKE_CYCLES)) i_chk (
  .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i), .scl_i(scl_i),
  .sda_oe_o(sda_oe_o), .sleep_request_o(sleep_request_o),
  .self_check_enable_o(self_check_enable_o), .reference_check_mode_o(reference_check_mode_o),
  .thermal_output_select_o(thermal_output_select_o), .measure_valid_o(measure_valid_o));

// ---- i2c_master_model.sv ----
// Behavioural two-wire bus master: drives SCL, pulls SDA low when asked.
// Assumes the bench resolves SDA with a pull-up; 160 ns bus clock period.
module i2c_master_model (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_pull_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Bus idle: both lines high
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end
  // Advance n clocks, then settle just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask
  // Data falls while the clock is high; also serves as a repeated start
  task automatic start_c;
    sda_pull_o = 1'b0;
    tick(3);
    scl_o = 1'b1;
    tick(3);
    sda_pull_o = 1'b1;
    tick(3);
    scl_o = 1'b0;
    tick(2);
  endtask
  // Data rises while the clock is high
  task automatic stop_c;
    sda_pull_o = 1'b1;
    tick(3);
    scl_o = 1'b1;
    tick(3);
    sda_pull_o = 1'b0;
    tick(4);
  endtask
  // Long low phase so the slave's late drive change lands before the rise
  task automatic bit_io(input logic b, output logic r);
    sda_pull_o = !b;
    tick(3);
    scl_o = 1'b1;
    tick(2);
    r = sda_i;
    tick(1);
    scl_o = 1'b0;
    tick(2);
  endtask
  // Eight bits MSB first, then the acknowledge slot
  task automatic xfer(input logic [7:0] tx, input logic b9, output logic [7:0] rx,
                      output logic r9);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(b9, r9);
  endtask
endmodule // i2c_master_model

// ---- test_accel_i2c_slave_regs.sv ----
// Self-checking bench for the accelerometer two-wire slave.
// Assumes the design header and the master model compile first.
`include "accel_map.vh"
module test_accel_i2c_slave_regs;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int REFRESH = 20;
  localparam int WAKE = 10;
  logic clk = 1'b0;
  logic rst_n, clk_en;
  logic [2:0] strap, pos;
  logic [11:0] x_in, y_in, t_in, ex, ey, et;
  logic [7:0] ctrl_m, rx;
  logic ack;
  wire scl, pull, dev_oe, dev_sda, valid, sda;
  wire [3:0] pins;
  int n_fail = 0;
  int cmp_count = 0;
  // Open-drain wire with pull-up
  assign sda = (dev_oe ? dev_sda : 1'b1) & ~pull;
  always #10 clk = ~clk;
  accel_i2c_slave_regs #(.REFRESH_CYCLES(REFRESH), .WAKE_CYCLES(WAKE)) i_dut (
    .sys_clk_i(clk), .reset_n_i(rst_n), .clk_en_i(clk_en), .scl_i(scl), .sda_i(sda),
    .sda_o(dev_sda), .sda_oe_o(dev_oe), .addr_strap_i(strap), .x_accel_i(x_in),
    .y_accel_i(y_in), .thermal_result_i(t_in), .sleep_request_o(pins[0]),
    .self_check_enable_o(pins[1]), .reference_check_mode_o(pins[2]),
    .thermal_output_select_o(pins[3]), .measure_valid_o(valid));
  i2c_master_model i_master (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_pull_o(pull));
  // ----------------------------------------------------------------
  // Expectations and helpers
  // ----------------------------------------------------------------
  // Window byte at a position, from the bench's own copies
  function automatic logic [7:0] exp_byte(input logic [2:0] p);
    logic [11:0] xt;
    xt = ctrl_m[3] ? et : ex;
    case (p)
      3'h0: exp_byte = ctrl_m;
      3'h1: exp_byte = {4'h0, xt[11:8]};
      3'h2: exp_byte = xt[7:0];
      3'h3: exp_byte = {4'h0, ey[11:8]};
      3'h4: exp_byte = ey[7:0];
      default: exp_byte = 8'h00;
    endcase
  endfunction
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic close_out;
    if (n_fail == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // New converter words; the model follows only when results may refresh
  task automatic new_inputs(input logic apply);
    x_in = 12'($urandom);
    y_in = 12'($urandom);
    t_in = 12'($urandom);
    if (apply) begin
      ex = x_in;
      ey = y_in;
      et = t_in;
    end
    tick(3 * REFRESH + 5);
  endtask
  task automatic addr_ptr(input logic [7:0] ptr);
    i_master.start_c();
    i_master.xfer({`DEV_ADDR_UPPER, strap, 1'b0}, 1'b1, rx, ack);
    chk("address ack", 8'h00, {7'h0, ack});
    i_master.xfer(ptr, 1'b1, rx, ack);
    chk("pointer ack", 8'h00, {7'h0, ack});
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    addr_ptr(ptr);
    i_master.xfer(d, 1'b1, rx, ack);
    chk("data ack", 8'h00, {7'h0, ack});
    i_master.stop_c();
    if (ptr == 8'h00) ctrl_m = d;
    tick(2);
    chk("control pins", {4'h0, ctrl_m[3:0]}, {4'h0, pins});
  endtask
  // Pointer write, repeated start, then n bytes; the last one is refused
  task automatic rd(input logic [7:0] ptr, input logic [2:0] p, input int n);
    addr_ptr(ptr);
    i_master.start_c();
    i_master.xfer({`DEV_ADDR_UPPER, strap, 1'b1}, 1'b1, rx, ack);
    chk("read address ack", 8'h00, {7'h0, ack});
    for (int k = 0; k < n; k++) begin
      i_master.xfer(8'hff, k == n - 1, rx, ack);
      chk("read byte", exp_byte(p), rx);
      p = (p == `POS_LAST) ? 3'h0 : p + 3'h1;
    end
    i_master.stop_c();
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    close_out();
  end
  initial begin
    void'($urandom(32'h0c6cfa56));
    rst_n = 1'b0;
    clk_en = 1'b1;
    strap = 3'($urandom);
    {x_in, y_in, t_in} = 36'h0;
    ctrl_m = `CTRL_RESET;
    tick(20);
    rst_n = 1'b1;
    chk("control pins", 8'h00, {4'h0, pins});
    chk("valid at reset", 8'h00, {7'h0, valid});
    new_inputs(1'b1);
    rd(8'h00, 3'h0, 9);
    wr(8'h00, 8'hfa);
    rd(8'h00, 3'h0, 3);
    repeat (6) begin
      wr(8'h00, 8'($urandom) & 8'hfe);
      new_inputs(1'b1);
      pos = 3'($urandom_range(4));
      rd({5'h0, pos}, pos, 1 + $urandom_range(8));
    end
    // Pointer beyond the window restarts at the control byte
    rd(8'h09, 3'h0, 2);
    // Data aimed at a read-only position leaves control alone
    wr(8'h03, 8'h55);
    for (int k = 0; k < 2; k++) begin
      i_master.start_c();
      i_master.xfer(k ? {4'h3, strap, 1'b0} : {`DEV_ADDR_UPPER, strap ^ 3'h5, 1'b0},
                    1'b1, rx, ack);
      chk("foreign ack", 8'h01, {7'h0, ack});
      i_master.stop_c();
    end
    // Asleep: results frozen; awake again: fresh results
    wr(8'h00, 8'h01);
    new_inputs(1'b0);
    chk("sleep valid", 8'h00, {7'h0, valid});
    rd(8'h01, 3'h1, 4);
    wr(8'h00, 8'h00);
    new_inputs(1'b1);
    chk("measure valid", 8'h01, {7'h0, valid});
    rd(8'h01, 3'h1, 4);
    // Reset in mid-run, with a new address strap
    rst_n = 1'b0;
    tick(3);
    strap = strap + 3'h1;
    ctrl_m = `CTRL_RESET;
    rst_n = 1'b1;
    chk("control pins", 8'h00, {4'h0, pins});
    // Enable low freezes the wake count, so results stay not valid
    clk_en = 1'b0;
    tick(30);
    chk("frozen valid", 8'h00, {7'h0, valid});
    clk_en = 1'b1;
    new_inputs(1'b1);
    rd(8'h00, 3'h0, 5);
    close_out();
  end
endmodule // test_accel_i2c_slave_regs
